// ---- include/bsid_pkg.sv ----
// shared constants and types of the boundary-scan instruction decode block
// assumes a 4-bit instruction register and a 32-bit identification register
package bsid_pkg;

    // ************************************************************
    // instruction register
    // ************************************************************
    localparam int IR_W = 4;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_SAMPLE = 4'h1;
    localparam logic [3:0] INSTR_IDCODE = 4'h2;
    localparam logic [3:0] INSTR_HIGHZ = 4'h3;
    localparam logic [3:0] INSTR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;  // two low bits read 01
    localparam logic [3:0] INSTR_RESET = INSTR_IDCODE;

    // ************************************************************
    // identification register layout
    // ************************************************************
    localparam int ID_W = 32;
    localparam int ID_MANUF_LSB = 1;
    localparam int ID_PART_LSB = 12;
    localparam int ID_VER_LSB = 28;
    localparam logic ID_MARKER = 1'h1;

    // ************************************************************
    // tap states, one-hot
    // ************************************************************
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } bsid_state_t;

    // which data register sits between the serial pins
    typedef enum logic [1:0] {
        PATH_BYP = 2'h0,
        PATH_ID = 2'h1,
        PATH_BSR = 2'h2
    } bsid_path_t;

    // unassigned codes fall back to the bypass path
    function automatic bsid_path_t bsid_decode(input logic [3:0] instr);
        case (instr)
            INSTR_EXTEST, INSTR_SAMPLE: bsid_decode = PATH_BSR;
            INSTR_IDCODE: bsid_decode = PATH_ID;
            default: bsid_decode = PATH_BYP;
        endcase
    endfunction

endpackage

// ---- include/bsid_if.sv ----
// strobes and mode lines from the tap core to the boundary register
// assumes every strobe is one core clock wide
`timescale 1ns/100ps
interface bsid_if;
    logic capture;  // capture-dr edge, boundary path selected
    logic shift;    // shift-dr edge, boundary path selected
    logic update;   // update-dr falling edge, boundary path selected
    logic tdi;      // synchronised serial input
    logic extest;   // external test mode is current
    logic highz;    // all outputs forced off
    logic bsr_so;   // boundary register serial output

    modport tap (output capture, shift, update, tdi, extest, highz, input bsr_so);
    modport bsr (input capture, shift, update, tdi, extest, highz, output bsr_so);
endinterface

// ---- verilog/bsid_boundary.sv ----
// boundary register: input cells, output cells and one enable cell
// assumes the strobes of the interface come from the core clock domain
`timescale 1ns/100ps
module bsid_boundary
    import bsid_pkg::*;
#(
    parameter int N_PINS = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    bsid_if.bsr bus,
    input wire logic [N_PINS-1:0] i_func_out,
    input wire logic i_func_oe,
    input wire logic [N_PINS-1:0] i_pin_in,
    output logic [N_PINS-1:0] o_pad_out,
    output logic o_pad_oe,
    output logic [N_PINS-1:0] o_core_in
);
    localparam int L = 2 * N_PINS + 1;

    logic [N_PINS-1:0] pin_s1;
    logic [N_PINS-1:0] pin_s2;
    logic [L-1:0] bsr;
    logic [L-1:0] upd;
    logic [L-1:0] next_bsr;
    logic [N_PINS-1:0] next_pad_out;
    logic next_pad_oe;

    // ************************************************************
    // shift and update stages
    // ************************************************************
    // capture takes pin levels, functional drive and enable
    assign next_bsr = bus.capture ? {i_func_oe, i_func_out, pin_s2}
                    : bus.shift ? {bus.tdi, bsr[L-1:1]} : bsr;
    assign bus.bsr_so = bsr[0];
    // pads follow update cells only under external
    assign next_pad_out = bus.extest ? upd[2*N_PINS-1:N_PINS] : i_func_out;
    assign next_pad_oe = bus.highz ? 1'h0 : bus.extest ? upd[L-1] : i_func_oe;

    // pins are asynchronous to the core clock, two stages first
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= i_pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // update cells hold preloaded data so extest starts from known levels
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bsr <= '0;
            upd <= '0;
        end else begin
            bsr <= next_bsr;
            if (bus.update) begin
                upd <= bsr;
            end
        end
    end

    // registered pad side; one core clock of latency is the price of clean outputs
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pad_out <= '0;
            o_pad_oe <= 1'h0;
            o_core_in <= '0;
        end else begin
            o_pad_out <= next_pad_out;
            o_pad_oe <= next_pad_oe;
            o_core_in <= pin_s2;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_highz_pads_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        bus.highz |=> !o_pad_oe)
        else $error("pad enable active under high-impedance");
    a_extest_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        bus.extest |=> o_pad_out == $past(upd[2*N_PINS-1:N_PINS]))
        else $error("extest pads not driven from update cells");
    a_normal_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !bus.extest |=> o_pad_out == $past(i_func_out))
        else $error("functional drive disturbed outside extest");
endmodule

// ---- verilog/bsid_tap.sv ----
// boundary-scan tap core: state machine, instruction and data registers
// assumes tck, tms, tdi and trst arrive asynchronously and tck is much slower
// than the core clock, so its edges are found by sampling
// Functional notes
// - extest puts boundary register between tdi and tdo, external test mode.
// - extest drives pins from output cells, captures pin levels into cells.
// - idcode keeps normal function and selects identification register.
// - identification register is 32 bits: maker, part and version codes.
// - reading identification register never disturbs functional operation.
// - after reset or test-logic-reset a data scan returns identification.
// - sample keeps normal operation, selects boundary, captures functional pins.
// - sample accepts shifted preload data; controller preloads before extest.
// - high-impedance instruction disables every output.
// - high-impedance uses one-bit bypass; shifting keeps outputs disabled.
// - bypass keeps normal operation and routes tdi to tdo through one stage.
// - 4-bit instruction: extest 0, sample 1, idcode 2, highz 3, bypass f.
// - bypass stage loads zero at capture-dr rising edge.
// - capture-ir loads fixed pattern with low bits 01.
// - tap advances on rising tck only, steered by tms.
`timescale 1ns/100ps
module bsid_tap
    import bsid_pkg::*;
#(
    parameter int N_PINS = 8,
    parameter logic [3:0] ID_VERSION = 4'h1,    // arbitrary value
    parameter logic [15:0] ID_PART = 16'h5a5a,  // arbitrary value
    parameter logic [10:0] ID_MANUF = 11'h2a6   // arbitrary value
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_b,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic [N_PINS-1:0] i_func_out,
    input wire logic i_func_oe,
    input wire logic [N_PINS-1:0] i_pin_in,
    output logic [N_PINS-1:0] o_pad_out,
    output logic o_pad_oe,
    output logic [N_PINS-1:0] o_core_in
);
    localparam logic [ID_W-1:0] ID_VALUE =
        {ID_VERSION, ID_PART, ID_MANUF, ID_MARKER};

    // ************************************************************
    // synchronisers and edge detection
    // ************************************************************
    logic [3:0] s1;
    logic [3:0] s2;
    logic tck_d;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_s_b;
    logic tck_rise;
    logic tck_fall;

    assign tck_s = s2[0];
    assign tms_s = s2[1];
    assign tdi_s = s2[2];
    assign trst_s_b = s2[3];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // all four pins pass two flops; edges are taken from the second stage
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1 <= 4'h0;
            s2 <= 4'h0;
            tck_d <= 1'h0;
        end else begin
            s1 <= {i_trst_b, i_tdi, i_tms, i_tck};
            s2 <= s1;
            tck_d <= tck_s;
        end
    end

    // ************************************************************
    // tap state machine
    // ************************************************************
    bsid_state_t state;
    bsid_state_t next_state;

    // standard transition table; tms picks the branch
    always_comb begin
        case (state)
            TAP_RESET: next_state = tms_s ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_state = tms_s ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: next_state = tms_s ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: next_state = tms_s ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_state = tms_s ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_state = tms_s ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: next_state = tms_s ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: next_state = tms_s ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_state = tms_s ? TAP_SEL_DR : TAP_IDLE;
            default: next_state = TAP_RESET;
        endcase
    end

    // trst pin forces test-logic-reset; otherwise only rising tck moves
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= TAP_RESET;
        end else if (!trst_s_b) begin
            state <= TAP_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ************************************************************
    // instruction register
    // ************************************************************
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] instr;
    logic [IR_W-1:0] next_ir_sh;
    logic [IR_W-1:0] next_instr;
    logic in_reset;
    logic ir_update;

    assign in_reset = (state == TAP_RESET) || !trst_s_b;
    assign ir_update = tck_fall && (state == TAP_UPD_IR);
    assign next_ir_sh = (state == TAP_CAP_IR) ? IR_CAPTURE
                      : (state == TAP_SH_IR) ? {tdi_s, ir_sh[IR_W-1:1]} : ir_sh;
    // reset has priority so a stale update never survives test-logic-reset
    assign next_instr = in_reset ? INSTR_RESET
                      : ir_update ? ir_sh : instr;

    // shift stages move on rising tck, the current instruction on falling
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ir_sh <= IR_CAPTURE;
            instr <= INSTR_RESET;
        end else begin
            if (tck_rise) begin
                ir_sh <= next_ir_sh;
            end
            instr <= next_instr;
        end
    end

    // ************************************************************
    // instruction decode
    // ************************************************************
    bsid_path_t path;
    logic sel_bsr;
    logic sel_id;
    logic sel_byp;

    assign path = bsid_decode(instr);
    assign sel_bsr = (path == PATH_BSR);
    assign sel_id = (path == PATH_ID);
    assign sel_byp = (path == PATH_BYP);

    // ************************************************************
    // bypass and identification registers
    // ************************************************************
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic cap_dr;
    logic sh_dr;

    assign cap_dr = tck_rise && (state == TAP_CAP_DR);
    assign sh_dr = tck_rise && (state == TAP_SH_DR);

    // the id register is read-only; nothing here reaches functional logic
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            byp <= 1'h0;
            id_sh <= ID_VALUE;
        end else begin
            if (cap_dr && sel_byp) begin
                byp <= 1'h0;
            end else if (sh_dr && sel_byp) begin
                byp <= tdi_s;
            end
            if (cap_dr && sel_id) begin
                id_sh <= ID_VALUE;
            end else if (sh_dr && sel_id) begin
                id_sh <= {tdi_s, id_sh[ID_W-1:1]};
            end
        end
    end

    // ************************************************************
    // boundary register and pad control
    // ************************************************************
    bsid_if bus ();

    assign bus.capture = cap_dr && sel_bsr;
    assign bus.shift = sh_dr && sel_bsr;
    assign bus.update = tck_fall && (state == TAP_UPD_DR) && sel_bsr;
    assign bus.tdi = tdi_s;
    assign bus.extest = (instr == INSTR_EXTEST);
    assign bus.highz = (instr == INSTR_HIGHZ);

    bsid_boundary #(
        .N_PINS(N_PINS)
    ) u_boundary (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .bus(bus),
        .i_func_out(i_func_out),
        .i_func_oe(i_func_oe),
        .i_pin_in(i_pin_in),
        .o_pad_out(o_pad_out),
        .o_pad_oe(o_pad_oe),
        .o_core_in(o_core_in)
    );

    // ************************************************************
    // serial output
    // ************************************************************
    logic shifting;
    logic dr_bit;
    logic next_tdo;

    assign shifting = (state == TAP_SH_IR) || (state == TAP_SH_DR);
    assign dr_bit = sel_bsr ? bus.bsr_so : sel_id ? id_sh[0] : byp;
    assign next_tdo = (state == TAP_SH_IR) ? ir_sh[0] : dr_bit;

    // tdo changes on falling tck so the controller samples a settled bit
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tdo <= 1'h0;
            o_tdo_oe <= 1'h0;
        end else if (tck_fall) begin
            o_tdo <= next_tdo;
            o_tdo_oe <= shifting;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // state machine and instruction register
    a_tap_holds_still: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (!tck_rise && trst_s_b) |=> $stable(state))
        else $error("tap state moved without rising tck");
    a_trst_to_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        !trst_s_b |=> state == TAP_RESET && instr == INSTR_RESET)
        else $error("test reset pin did not force test-logic-reset");
    a_ir_capture_01: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (tck_rise && state == TAP_CAP_IR) |=> ir_sh[1:0] == 2'b01)
        else $error("capture-ir pattern wrong");
    a_ir_update_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (ir_update && trst_s_b) |=> instr == $past(ir_sh))
        else $error("instruction not latched at update-ir");
    a_reset_to_id: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (state == TAP_RESET) |=> sel_id && instr == INSTR_IDCODE)
        else $error("test-logic-reset did not select identification");

    // data registers and serial output; each path must reach tdo one bit per tck
    a_id_capture: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (cap_dr && instr == INSTR_IDCODE) |=> id_sh == ID_VALUE)
        else $error("identification capture wrong");
    a_id_shift_in: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (sh_dr && sel_id) |=> id_sh == {$past(tdi_s), $past(id_sh[ID_W-1:1])})
        else $error("identification register did not shift");
    a_bypass_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (cap_dr && sel_byp) |=> !byp)
        else $error("bypass stage not cleared at capture-dr");
    a_bypass_tdo: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (tck_fall && state == TAP_SH_DR && sel_byp) |=> o_tdo == $past(byp) && o_tdo_oe)
        else $error("bypass bit not on tdo");
    a_bsr_tdo: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (tck_fall && state == TAP_SH_DR && sel_bsr) |=> o_tdo == $past(bus.bsr_so))
        else $error("boundary bit not on tdo");
    a_id_tdo: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (tck_fall && state == TAP_SH_DR && sel_id) |=> o_tdo == $past(id_sh[0]))
        else $error("identification bit not on tdo");
    a_ir_tdo: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (tck_fall && state == TAP_SH_IR) |=> o_tdo == $past(ir_sh[0]) && o_tdo_oe)
        else $error("instruction bit not on tdo");

    // decode of the current instruction
    a_unassigned_byp: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (instr > INSTR_HIGHZ) |-> sel_byp && !bus.extest && !bus.highz)
        else $error("unassigned code not treated as bypass");
    a_highz_bypass: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        bus.highz |-> sel_byp && !bus.extest)
        else $error("high-impedance did not select the bypass stage");

    c_id_shift: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        sh_dr && sel_id);
    c_extest_on: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        $rose(bus.extest));
    c_highz_on: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        bus.highz && sh_dr);
    c_preload: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        bus.update && instr == INSTR_SAMPLE);
    c_unassigned: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
        sh_dr && sel_byp && instr != INSTR_BYPASS && instr != INSTR_HIGHZ);
endmodule

// ---- tb/bsid_ctrl_model.sv ----
// partner model: an external boundary-scan controller working the test pins
// assumes callers enter its tasks 2 ns after a core clock edge
`timescale 1ns/100ps
module bsid_ctrl_model (
    input wire logic i_tdo,
    input wire logic i_tdo_oe,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_b
);
    // ************************************************************
    // pin driving
    // ************************************************************
    // power-up levels: tck parked low, test reset held until released
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_b = 1'b0;
    end

    // one tck period; tdo is taken just before the rise, where it has settled
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #80;
        // an undriven tdo reads inverted, so a missing enable spoils the data
        tdo = i_tdo_oe ? i_tdo : ~i_tdo;
        o_tck = 1'b1;  // state moves only on this edge, steered by tms
        #80;
        o_tck = 1'b0;
    endtask

    // five highs on tms reach test-logic-reset from anywhere, then idle
    task automatic to_reset();
        logic d;
        for (int i = 0; i < 5; i++) begin
            tick(1'b1, 1'b0, d);
        end
        tick(1'b0, 1'b0, d);
    endtask

    // test reset pin pulse, long enough for the synchroniser, then idle
    task automatic pulse_trst();
        logic d;
        o_trst_b = 1'b0;
        #100;
        o_trst_b = 1'b1;
        #50;
        tick(1'b0, 1'b0, d);
    endtask

    // full ir or dr scan from idle back to idle; bits go lsb first
    task automatic scan(input logic is_ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b0, d);
        if (is_ir) begin
            tick(1'b1, 1'b0, d);
        end
        tick(1'b0, 1'b0, d);
        tick(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);  // preload data goes in this way
            dout[i] = d;
        end
        // tdi keeps toggling after the frame so a stale level cannot pass
        tick(1'b1, ~din[n - 1], d);
        tick(1'b0, din[n - 1], d);
    endtask
endmodule

// ---- tb/test_boundary_scan_instruction_decode.sv ----
// self-checking bench for the boundary-scan instruction decode block
// assumes the tap core is the top and the controller model drives its pins
`timescale 1ns/100ps
module test_boundary_scan_instruction_decode
    import bsid_pkg::*;
;
    // ************************************************************
    // set-up
    // ************************************************************
    localparam int NP = 8;
    localparam int BSR_W = 2 * NP + 1;
    localparam logic [63:0] MASK48 = 64'hffff_ffff_ffff;
    // identification fields, arbitrary values
    localparam logic [3:0] T_VER = 4'h1;
    localparam logic [15:0] T_PART = 16'h5a5a;
    localparam logic [10:0] T_MANUF = 11'h2a6;
    localparam logic [31:0] EXP_ID = {T_VER, T_PART, T_MANUF, 1'h1};

    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic tck, tms, tdi, trst_b, tdo, tdo_oe;
    logic [NP-1:0] func_out = '0;
    logic [NP-1:0] pin_in = '0;
    logic func_oe = 1'b0;
    logic [NP-1:0] pad_out, core_in;
    logic pad_oe;
    int n_fail = 0;
    int samples_checked = 0;
    logic [31:0] rnd = 32'ha3e88376;

    always #5 i_core_clk = ~i_core_clk;

    bsid_tap #(.N_PINS(NP), .ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MANUF(T_MANUF)) dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .i_trst_b(trst_b), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_func_out(func_out), .i_func_oe(func_oe), .i_pin_in(pin_in),
        .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_core_in(core_in));

    bsid_ctrl_model ctrl (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_b(trst_b));

    // ************************************************************
    // expectations and checks
    // ************************************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // serial path length per code; anything unassigned means bypass
    function automatic int path_len(input logic [3:0] c);
        if (c == 4'h0 || c == 4'h1) return BSR_W;
        if (c == 4'h2) return 32;
        return 1;
    endfunction

    // captured bits come out first, then tdi delayed by the path length
    function automatic logic [63:0] exp_scan(input int len, input logic [63:0] cap,
                                             input logic [63:0] din);
        return (cap & ((64'h1 << len) - 64'h1)) | (din << len);
    endfunction

    task automatic check(input string what, input logic [63:0] expv, input logic [63:0] got);
        samples_checked++;
        if (got !== expv) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic close_out();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // fresh functional levels, held for a whole instruction round
    task automatic new_func();
        rnd = lfsr_next(rnd);
        func_out = rnd[7:0];
        func_oe = rnd[8];
        pin_in = rnd[23:16];
    endtask

    // 48-bit data scan; boundary scans also refresh the update cells
    task automatic dr_check(input logic [3:0] code, inout logic [BSR_W-1:0] upd);
        logic [63:0] din, dout, cap;
        din = {rnd, lfsr_next(rnd)};
        rnd = lfsr_next(lfsr_next(rnd));
        cap = (code == 4'h2) ? 64'(EXP_ID) : 64'h0;
        if (path_len(code) == BSR_W) begin
            cap = 64'({func_oe, func_out, pin_in});
            upd = din[47:31];
        end
        ctrl.scan(1'b0, 48, din, dout);
        cap = exp_scan(path_len(code), cap, din) & MASK48;
        check("dr_path", cap, dout & MASK48);
    endtask

    // pad group after the link has gone quiet; tck stands still meanwhile
    task automatic pads_check(input logic [3:0] code, input logic [BSR_W-1:0] upd);
        repeat (8) @(posedge i_core_clk);
        #2;
        check("core_in", 64'(pin_in), 64'(core_in));
        if (code == 4'h0) begin
            check("pad_out", 64'(upd[15:8]), 64'(pad_out));
            check("pad_oe", 64'(upd[16]), 64'(pad_oe));
        end else if (code == 4'h3) begin
            check("pad_oe", 64'h0, 64'(pad_oe));
        end else begin
            check("pad_out", 64'(func_out), 64'(pad_out));
            check("pad_oe", 64'(func_oe), 64'(pad_oe));
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        #500000;
        n_fail++;
        close_out();
    end

    initial begin
        logic [63:0] dout;
        logic [3:0] codes [6];
        logic [BSR_W-1:0] upd;
        upd = '0;
        repeat (12) @(posedge i_core_clk);
        #2;
        i_rst_b = 1'b1;
        repeat (4) @(posedge i_core_clk);
        #2;
        ctrl.pulse_trst();
        ctrl.to_reset();
        new_func();
        dr_check(4'h2, upd);
        pads_check(4'h2, upd);
        // sample first so its data is preloaded when extest becomes current
        codes = '{4'h1, 4'h0, 4'h3, 4'h2, 4'hf, 4'h4 + 4'(rnd % 11)};
        foreach (codes[k]) begin
            new_func();
            ctrl.scan(1'b1, 4, {60'h0, codes[k]}, dout);
            check("ir_capture", 64'h1, dout & 64'hf);
            pads_check(codes[k], upd);
            dr_check(codes[k], upd);
            pads_check(codes[k], upd);
        end
        // both ways into test-logic-reset bring identification back
        for (int m = 0; m < 2; m++) begin
            ctrl.scan(1'b1, 4, 64'hf, dout);
            if (m == 0) begin
                ctrl.to_reset();
            end else begin
                ctrl.pulse_trst();
            end
            dr_check(4'h2, upd);
            pads_check(4'h2, upd);
        end
        close_out();
    end
endmodule
